//--- hw/setpoint_counter_output_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Output one sets at first set point
// RULE2 - Zero time one: hold until reset/two
// RULE3 - Down terminal: output two, reload, continue
// RULE4 - Timed two end releases both outputs
// RULE5 - Zero time two disables automatic reset
// RULE6 - Fourth mode up: clear at pulse end
// RULE7 - Fourth mode down: reload at pulse end
// RULE8 - Total gains count on automatic reset
// RULE9 - Fifth counter up: one when count>=first_set_point
// RULE10 - Fifth counter: two while count>=second_set_point
// RULE11 - Fifth counter down: one when count<=first_set_point
// RULE12 - Fifth mode totals only on manual reset
// RULE13 - Fifth timer: zero time one ends at second_set_point
// RULE14 - Fifth timer up: clear, toggle output two
// RULE15 - Fifth timer down: reload, set output two
// RULE16 - Batch up: clear, output two, timed/latched
// RULE17 - Batch down: reload, output two
// RULE18 - Each output two bumps batch; match sets one
// RULE19 - Batch output one timed or latched
// RULE20 - Batch auto variant clears batch count
// RULE21 - Frequency timeout clears the count
// RULE22 - Pulse time 0..99.99 s, zero latches
// RULE23 - Pulse timers run from 10 ms tick
module setpoint_counter_output_ctrl #(
	parameter int TICK_CYCLES = setpoint_pkg::TICK_CYCLES // Cycles per 10 ms tick
) (
	input wire logic clk_sys_i, // 40 MHz clock
	input wire logic reset_i, // Sync reset, active high
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB enable
	input wire logic pwrite_i, // APB direction
	input wire logic [setpoint_pkg::AW-1:0] paddr_i, // APB byte address
	input wire logic [31:0] pwdata_i, // APB write data
	output logic [31:0] prdata_o, // APB read data
	output logic pready_o, // APB ready
	output logic pslverr_o, // APB error
	input wire logic first_channel_input_i, // Count pulse pin
	input wire logic manual_reset_i, // Manual reset pin
	output logic out1_o, // First output
	output logic out2_o // Second output
);
	typedef struct packed {
		setpoint_pkg::func_t fn;
		setpoint_pkg::omode_t mode;
		logic down;
		logic bauto;
		logic en;
		logic [setpoint_pkg::CNT_W-1:0] first_set_point;
		logic [setpoint_pkg::CNT_W-1:0] second_set_point;
		logic [setpoint_pkg::CNT_W-1:0] count;
		logic [setpoint_pkg::CNT_W-1:0] total;
		logic [setpoint_pkg::CNT_W-1:0] batch;
		logic [setpoint_pkg::PT_W-1:0] pt1;
		logic [setpoint_pkg::PT_W-1:0] pt2;
		logic [setpoint_pkg::TO_W-1:0] tout;
		logic [setpoint_pkg::TO_W-1:0] to_cnt;
		logic [setpoint_pkg::TICK_W-1:0] presc;
		logic tick;
		logic ch_m;
		logic ch_s;
		logic ch_p;
		logic mr_m;
		logic mr_s;
		logic mr_p;
		logic o1;
		logic o2;
		logic [31:0] rdata;
		logic slverr;
	} st_t;
	st_t r, n;

	localparam logic [setpoint_pkg::TICK_W-1:0] TICK_LAST = setpoint_pkg::TICK_W'(TICK_CYCLES - 1);
	localparam logic [setpoint_pkg::CNT_W-1:0] ONE = 32'h0000_0001;

	logic ch_edge, man, sw_rst, step, reach1, reach2, ar_ok, to_hit;
	logic act1, act2, exp1, exp2, is_ctr;
	logic [setpoint_pkg::CNT_W-1:0] nc, rl, bnext;
	logic [31:0] rmux;
	logic rerr;

	// Read decode; unmapped offsets answer with error and zero
	always_comb
	begin
		rmux = 32'h0000_0000;
		rerr = 1'b0;
		unique case (paddr_i)
			setpoint_pkg::OFF_CTRL:
			begin
				rmux[setpoint_pkg::CTRL_FN_LSB +: 3] = r.fn;
				rmux[setpoint_pkg::CTRL_MODE_LSB +: 2] = r.mode;
				rmux[setpoint_pkg::CTRL_DOWN_BIT] = r.down;
				rmux[setpoint_pkg::CTRL_BAUTO_BIT] = r.bauto;
				rmux[setpoint_pkg::CTRL_EN_BIT] = r.en;
			end
			setpoint_pkg::OFF_CMD: rmux = 32'h0000_0000;
			setpoint_pkg::OFF_FIRST_SET_POINT: rmux = r.first_set_point;
			setpoint_pkg::OFF_SECOND_SET_POINT: rmux = r.second_set_point;
			setpoint_pkg::OFF_PT1: rmux[setpoint_pkg::PT_W-1:0] = r.pt1;
			setpoint_pkg::OFF_PT2: rmux[setpoint_pkg::PT_W-1:0] = r.pt2;
			setpoint_pkg::OFF_TOUT: rmux[setpoint_pkg::TO_W-1:0] = r.tout;
			setpoint_pkg::OFF_STAT:
			begin
				rmux[setpoint_pkg::STAT_O1_BIT] = r.o1;
				rmux[setpoint_pkg::STAT_O2_BIT] = r.o2;
			end
			setpoint_pkg::OFF_COUNT: rmux = r.count;
			setpoint_pkg::OFF_TOTAL: rmux = r.total;
			setpoint_pkg::OFF_BATCH: rmux = r.batch;
			default: rerr = 1'b1;
		endcase
	end

	// Event decode from the current state
	always_comb
	begin
		ch_edge = r.ch_s & ~r.ch_p;
		sw_rst = psel_i & penable_i & pwrite_i & (paddr_i == setpoint_pkg::OFF_CMD)
			& pwdata_i[setpoint_pkg::CMD_RST_BIT];
		man = (r.mr_s & ~r.mr_p) | sw_rst;
		is_ctr = (r.fn == setpoint_pkg::FN_COUNTER) || (r.fn == setpoint_pkg::FN_TOTAL);
		step = r.en & ((r.fn == setpoint_pkg::FN_TIMER) ? r.tick : ch_edge);
		nc = r.down ? (r.count - ONE) : (r.count + ONE);
		rl = r.down ? r.second_set_point : setpoint_pkg::CNT_RST;
		reach1 = step && (nc == r.first_set_point);
		reach2 = step && (r.down ? (nc == setpoint_pkg::CNT_RST) : (nc == r.second_set_point));
		ar_ok = (r.pt2 != setpoint_pkg::PT_RST); // RULE5
		to_hit = (r.fn == setpoint_pkg::FN_FREQ) && r.tick && !ch_edge && (r.to_cnt >= r.tout);
		bnext = r.batch + ONE;
	end

	// Whole next state: bus writes, counting, outputs, manual reset last
	always_comb
	begin
		n = r;
		act1 = 1'b0;
		act2 = 1'b0;
		n.tick = 1'b0;
		if (r.presc == TICK_LAST)
		begin
			n.presc = '0;
			n.tick = 1'b1; // RULE23
		end
		else
			n.presc = r.presc + setpoint_pkg::TICK_W'(1);
		// Two flops before any use of the pins
		n.ch_m = first_channel_input_i;
		n.ch_s = r.ch_m;
		n.ch_p = r.ch_s;
		n.mr_m = manual_reset_i;
		n.mr_s = r.mr_m;
		n.mr_p = r.mr_s;
		// Read data and error are caught in setup so they come from flops
		if (psel_i && !penable_i)
		begin
			n.rdata = rmux;
			n.slverr = rerr;
		end
		if (psel_i && penable_i && pwrite_i)
		begin
			unique case (paddr_i)
				setpoint_pkg::OFF_CTRL:
				begin
					// Illegal function codes fall back to plain counting
					n.fn = (pwdata_i[setpoint_pkg::CTRL_FN_LSB +: 3] > setpoint_pkg::FN_FREQ) ?
						setpoint_pkg::FN_COUNTER :
						setpoint_pkg::func_t'(pwdata_i[setpoint_pkg::CTRL_FN_LSB +: 3]);
					n.mode = setpoint_pkg::omode_t'(pwdata_i[setpoint_pkg::CTRL_MODE_LSB +: 2]);
					n.down = pwdata_i[setpoint_pkg::CTRL_DOWN_BIT];
					n.bauto = pwdata_i[setpoint_pkg::CTRL_BAUTO_BIT];
					n.en = pwdata_i[setpoint_pkg::CTRL_EN_BIT];
				end
				setpoint_pkg::OFF_FIRST_SET_POINT: n.first_set_point = pwdata_i;
				setpoint_pkg::OFF_SECOND_SET_POINT: n.second_set_point = pwdata_i;
				setpoint_pkg::OFF_PT1: n.pt1 = (pwdata_i > 32'(setpoint_pkg::PT_MAX)) ?
					setpoint_pkg::PT_MAX : pwdata_i[setpoint_pkg::PT_W-1:0]; // RULE22
				setpoint_pkg::OFF_PT2: n.pt2 = (pwdata_i > 32'(setpoint_pkg::PT_MAX)) ?
					setpoint_pkg::PT_MAX : pwdata_i[setpoint_pkg::PT_W-1:0]; // RULE22
				setpoint_pkg::OFF_TOUT: n.tout = pwdata_i[setpoint_pkg::TO_W-1:0];
				default: n.first_set_point = r.first_set_point;
			endcase
		end
		if (step)
			n.count = nc;
		if (r.fn == setpoint_pkg::FN_FREQ)
		begin
			// Ticks since the last pulse, saturating
			if (ch_edge)
				n.to_cnt = '0;
			else if (r.tick && r.to_cnt != '1)
				n.to_cnt = r.to_cnt + setpoint_pkg::TO_W'(1);
			if (to_hit)
				n.count = setpoint_pkg::CNT_RST; // RULE21
		end
		else if (r.mode == setpoint_pkg::OM_AR5 && is_ctr)
		begin
			// Pure comparator outputs, pulse times unused; new set points count at once
			n.o1 = r.down ? ($signed(n.count) <= $signed(n.first_set_point)) // RULE11
				: ($signed(n.count) >= $signed(n.first_set_point)); // RULE9
			n.o2 = ($signed(n.count) >= $signed(n.second_set_point)); // RULE10
		end
		else if (r.mode == setpoint_pkg::OM_AR5 && r.fn == setpoint_pkg::FN_TIMER)
		begin
			// Expiry first so a fresh set in the same cycle wins
			if (exp1)
				n.o1 = 1'b0;
			if (reach1)
			begin
				n.o1 = 1'b1;
				act1 = 1'b1;
			end
			if (reach2)
			begin
				if (r.pt1 == setpoint_pkg::PT_RST)
					n.o1 = 1'b0; // RULE13
				if (r.down)
				begin
					n.count = r.second_set_point; // RULE15
					n.o2 = 1'b1; // RULE15
				end
				else
				begin
					n.count = setpoint_pkg::CNT_RST; // RULE14
					n.o2 = ~r.o2; // RULE14
				end
			end
		end
		else
		begin
			// Expiries first: a set in the same cycle reloads its timer and wins
			if (exp1)
				n.o1 = 1'b0; // RULE1
			// Batch keeps output one apart from output two
			if (exp2)
			begin
				n.o2 = 1'b0; // RULE4 RULE16
				if (r.fn != setpoint_pkg::FN_BATCH)
				begin
					n.o1 = 1'b0; // RULE2 RULE4
					if (r.mode == setpoint_pkg::OM_AR4)
					begin
						if (r.fn == setpoint_pkg::FN_TOTAL)
							n.total = r.total + n.count; // RULE8
						n.count = rl; // RULE6 RULE7
					end
				end
			end
			if (reach1 && r.fn != setpoint_pkg::FN_BATCH)
			begin
				n.o1 = 1'b1; // RULE1
				act1 = 1'b1; // RULE1
			end
			if (reach2)
			begin
				n.o2 = 1'b1;
				act2 = 1'b1;
				if (r.fn == setpoint_pkg::FN_BATCH)
				begin
					n.count = rl; // RULE16 RULE17
					n.batch = bnext; // RULE18
					if (bnext == r.first_set_point)
					begin
						n.o1 = 1'b1; // RULE18
						act1 = 1'b1; // RULE19
						if (r.bauto)
							n.batch = setpoint_pkg::CNT_RST; // RULE20
					end
				end
				else if (r.mode == setpoint_pkg::OM_AR3 && ar_ok)
				begin
					if (r.fn == setpoint_pkg::FN_TOTAL)
						n.total = r.total + nc; // RULE8
					n.count = rl; // RULE3
				end
			end
		end
		// Manual reset wins over every other count change
		if (man)
		begin
			if (r.fn == setpoint_pkg::FN_TOTAL)
				n.total = r.total + r.count; // RULE12
			n.count = rl;
			n.o1 = 1'b0; // RULE2 RULE19
			n.o2 = 1'b0; // RULE16
			n.batch = setpoint_pkg::CNT_RST;
			n.to_cnt = '0;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			r <= '0;
			r.tout <= setpoint_pkg::TO_RST;
		end
		else
			r <= n;
	end

	// Output one pulse timer
	pulse_timer u_timer1 (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.tick_i(r.tick),
		.load_i(act1),
		.clear_i(man),
		.time_i(r.pt1),
		.expire_o(exp1)
	);

	// Output two pulse timer
	pulse_timer u_timer2 (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.tick_i(r.tick),
		.load_i(act2),
		.clear_i(man),
		.time_i(r.pt2),
		.expire_o(exp2)
	);

	assign prdata_o = r.rdata;
	assign pslverr_o = r.slverr;
	assign pready_o = psel_i & penable_i;
	assign out1_o = r.o1;
	assign out2_o = r.o2;

	property p_first_set_point;
		@(posedge clk_sys_i) disable iff (reset_i)
		(reach1 && !man && r.mode != setpoint_pkg::OM_AR5 && is_ctr) |=> out1_o;
	endproperty
	a_first_set_point: assert property (p_first_set_point) else $error("output one missed set point"); // RULE1

	property p_latch1;
		@(posedge clk_sys_i) disable iff (reset_i)
		(out1_o && r.pt1 == setpoint_pkg::PT_RST && !man && r.mode != setpoint_pkg::OM_AR5
			&& !(exp2 && r.fn != setpoint_pkg::FN_BATCH)) |=> out1_o;
	endproperty
	a_latch1: assert property (p_latch1) else $error("latched output one dropped"); // RULE2

	property p_ar3_down;
		@(posedge clk_sys_i) disable iff (reset_i)
		(reach2 && !man && r.down && ar_ok && r.mode == setpoint_pkg::OM_AR3 && is_ctr)
			|=> (r.count == $past(r.second_set_point) && out2_o);
	endproperty
	a_ar3_down: assert property (p_ar3_down) else $error("terminal reload missed"); // RULE3

	property p_end2;
		@(posedge clk_sys_i) disable iff (reset_i)
		(exp2 && !reach1 && !reach2 && r.mode != setpoint_pkg::OM_AR5 && is_ctr)
			|=> (!out1_o && !out2_o);
	endproperty
	a_end2: assert property (p_end2) else $error("outputs not released together"); // RULE4

	property p_ar4_up;
		@(posedge clk_sys_i) disable iff (reset_i)
		(exp2 && !man && !r.down && r.mode == setpoint_pkg::OM_AR4 && is_ctr)
			|=> (r.count == setpoint_pkg::CNT_RST);
	endproperty
	a_ar4_up: assert property (p_ar4_up) else $error("count not cleared at pulse end"); // RULE6

	property p_cmp2;
		@(posedge clk_sys_i) disable iff (reset_i)
		(r.mode == setpoint_pkg::OM_AR5 && is_ctr && !man) ##1
			(r.mode == setpoint_pkg::OM_AR5 && is_ctr)
			|-> (out2_o == ($signed(r.count) >= $signed(r.second_set_point)));
	endproperty
	a_cmp2: assert property (p_cmp2) else $error("comparator output two wrong"); // RULE10

	property p_batch;
		@(posedge clk_sys_i) disable iff (reset_i)
		(reach2 && !man && r.fn == setpoint_pkg::FN_BATCH && r.mode != setpoint_pkg::OM_AR5
			&& !r.bauto) |=> (r.batch == $past(r.batch) + ONE && out2_o);
	endproperty
	a_batch: assert property (p_batch) else $error("batch count not bumped"); // RULE18

	property p_timeout;
		@(posedge clk_sys_i) disable iff (reset_i)
		to_hit |=> (r.count == setpoint_pkg::CNT_RST);
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout did not clear count"); // RULE21
endmodule // setpoint_counter_output_ctrl

//--- common/setpoint_pkg.sv
package setpoint_pkg;
	// Clock and pulse-time tick
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int TICK_W = 20;
	// Data widths
	localparam int CNT_W = 32;
	localparam int PT_W = 14;
	localparam int TO_W = 16;
	localparam int AW = 8;
	// Longest pulse time, 99.99 s in 10 ms steps
	localparam logic [PT_W-1:0] PT_MAX = 14'h270f;
	localparam logic [PT_W-1:0] PT_ONE = 14'h0001;
	// Register byte offsets
	localparam logic [AW-1:0] OFF_CTRL = 8'h00;
	localparam logic [AW-1:0] OFF_CMD = 8'h04;
	localparam logic [AW-1:0] OFF_FIRST_SET_POINT = 8'h08;
	localparam logic [AW-1:0] OFF_SECOND_SET_POINT = 8'h0c;
	localparam logic [AW-1:0] OFF_PT1 = 8'h10;
	localparam logic [AW-1:0] OFF_PT2 = 8'h14;
	localparam logic [AW-1:0] OFF_TOUT = 8'h18;
	localparam logic [AW-1:0] OFF_STAT = 8'h1c;
	localparam logic [AW-1:0] OFF_COUNT = 8'h20;
	localparam logic [AW-1:0] OFF_TOTAL = 8'h24;
	localparam logic [AW-1:0] OFF_BATCH = 8'h28;
	// Field positions
	localparam int CTRL_FN_LSB = 0;
	localparam int CTRL_MODE_LSB = 3;
	localparam int CTRL_DOWN_BIT = 5;
	localparam int CTRL_BAUTO_BIT = 6;
	localparam int CTRL_EN_BIT = 7;
	localparam int CMD_RST_BIT = 0;
	localparam int STAT_O1_BIT = 0;
	localparam int STAT_O2_BIT = 1;
	// Reset values
	localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
	localparam logic [PT_W-1:0] PT_RST = 14'h0000;
	localparam logic [TO_W-1:0] TO_RST = 16'h0064;
	// Counting functions
	typedef enum logic [2:0] {
		FN_COUNTER = 3'b000,
		FN_TOTAL = 3'b001,
		FN_TIMER = 3'b010,
		FN_BATCH = 3'b011,
		FN_FREQ = 3'b100
	} func_t;
	// Output functions
	typedef enum logic [1:0] {
		OM_MANUAL = 2'b00,
		OM_AR3 = 2'b01,
		OM_AR4 = 2'b10,
		OM_AR5 = 2'b11
	} omode_t;
endpackage

//--- hw/pulse_timer.sv
`timescale 1ns/1ps
module pulse_timer (
	input wire logic clk_sys_i, // System clock
	input wire logic reset_i, // Sync reset
	input wire logic tick_i, // 10 ms tick
	input wire logic load_i, // Output asserted
	input wire logic clear_i, // Manual reset
	input wire logic [setpoint_pkg::PT_W-1:0] time_i, // Pulse time, 10 ms units
	output logic expire_o // One-cycle expiry pulse
);
	typedef struct packed {
		logic [setpoint_pkg::PT_W-1:0] cnt;
		logic expire;
	} tmr_t;
	tmr_t r, n;

	// Zero time loads zero, which never expires, so the output stays latched
	always_comb
	begin
		n = r;
		n.expire = 1'b0;
		if (clear_i)
			n.cnt = setpoint_pkg::PT_RST;
		else if (load_i)
			n.cnt = time_i; // RULE23
		else if (tick_i && r.cnt != setpoint_pkg::PT_RST)
		begin
			n.cnt = r.cnt - setpoint_pkg::PT_ONE; // RULE23
			n.expire = (r.cnt == setpoint_pkg::PT_ONE); // RULE22
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			r <= '0;
		else
			r <= n;
	end

	assign expire_o = r.expire;

	property p_load;
		@(posedge clk_sys_i) disable iff (reset_i)
		(load_i && !clear_i && time_i != setpoint_pkg::PT_RST) |=> (r.cnt == $past(time_i));
	endproperty
	a_load: assert property (p_load) else $error("pulse time not loaded"); // RULE23

	property p_expire;
		@(posedge clk_sys_i) disable iff (reset_i)
		expire_o |-> ($past(r.cnt) == setpoint_pkg::PT_ONE && $past(tick_i));
	endproperty
	a_expire: assert property (p_expire) else $error("expiry without last tick"); // RULE22
endmodule // pulse_timer

//--- verification/field_source.sv
`timescale 1ns/1ps
module field_source (
	input wire logic clk_sys_i, // System clock
	output logic pulse_o, // Count pulse pin
	output logic reset_pin_o // Manual reset pin
);
	// Both pins rest low between commands
	initial
	begin
		pulse_o = 1'b0;
		reset_pin_o = 1'b0;
	end
	// Three high, three low: long enough for the two-flop synchroniser
	task automatic send_pulses(input int n);
		repeat (n)
		begin
			@(posedge clk_sys_i);
			pulse_o <= 1'b1;
			repeat (3) @(posedge clk_sys_i);
			pulse_o <= 1'b0;
			repeat (3) @(posedge clk_sys_i);
		end
	endtask
	// Push-button style manual reset
	task automatic press_reset;
		@(posedge clk_sys_i);
		reset_pin_o <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		reset_pin_o <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
	endtask
endmodule // field_source

//--- verification/test_setpoint_counter_output_ctrl.sv
`timescale 1ns/1ps
module test_setpoint_counter_output_ctrl;
	localparam int TK = 4;
	logic clk_sys_i;
	logic reset_i;
	logic psel_i;
	logic penable_i;
	logic pwrite_i;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic pin;
	logic rst_pin;
	logic out1_o;
	logic out2_o;
	logic last_err;
	logic [31:0] rd;
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;
	// 40 MHz system clock
	always #12.5 clk_sys_i = ~clk_sys_i;
	// Short tick keeps pulse times to a few cycles
	setpoint_counter_output_ctrl #(.TICK_CYCLES(TK)) i_setpoint_counter_output_ctrl (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.psel_i(psel_i),
		.penable_i(penable_i),
		.pwrite_i(pwrite_i),
		.paddr_i(paddr_i),
		.pwdata_i(pwdata_i),
		.prdata_o(prdata_o),
		.pready_o(pready_o),
		.pslverr_o(pslverr_o),
		.first_channel_input_i(pin),
		.manual_reset_i(rst_pin),
		.out1_o(out1_o),
		.out2_o(out2_o)
	);
	field_source i_field_source (
		.clk_sys_i(clk_sys_i),
		.pulse_o(pin),
		.reset_pin_o(rst_pin)
	);
	task automatic give_verdict;
		$display("mismatches %0d, checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Hang guard, far above the several hundred cycles needed
	always @(posedge clk_sys_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			give_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic oc(input logic [1:0] e);
		chk({30'h0, out2_o, out1_o}, {30'h0, e});
	endtask
	// One transfer, then an idle cycle so no signal is driven twice at one edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		@(posedge clk_sys_i);
		// Wait for the answer; only the hang guard ends a stuck wait
		while (pready_o !== 1'b1)
			@(posedge clk_sys_i);
		rd = prdata_o;
		last_err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// Set points and times, then control, then a manual reset to start clean
	task automatic cfg(input logic [7:0] c, input logic [31:0] s1, s2, p1, p2);
		apb(1'b1, setpoint_pkg::OFF_FIRST_SET_POINT, s1);
		apb(1'b1, setpoint_pkg::OFF_SECOND_SET_POINT, s2);
		apb(1'b1, setpoint_pkg::OFF_PT1, p1);
		apb(1'b1, setpoint_pkg::OFF_PT2, p2);
		apb(1'b1, setpoint_pkg::OFF_CTRL, {24'h0, c});
		apb(1'b1, setpoint_pkg::OFF_CMD, 32'h1);
	endtask
	task automatic t_regs;
		rchk(setpoint_pkg::OFF_TOUT, 32'h64);
		rchk(setpoint_pkg::OFF_STAT, 32'h0);
		apb(1'b1, setpoint_pkg::OFF_COUNT, 32'h5);
		rchk(setpoint_pkg::OFF_COUNT, 32'h0);
		apb(1'b1, setpoint_pkg::OFF_PT1, 32'h3fff);
		rchk(setpoint_pkg::OFF_PT1, {18'h0, setpoint_pkg::PT_MAX});
		apb(1'b0, 8'h2c, 32'h0);
		chk({31'h0, last_err}, 32'h1);
	endtask
	task automatic t_out1;
		cfg(8'h80, 32'h2, 32'h64, 32'h3, 32'h0);
		i_field_source.send_pulses(1);
		oc(2'b00);
		i_field_source.send_pulses(1);
		oc(2'b01);
		repeat (3 * TK + 2) @(posedge clk_sys_i);
		oc(2'b00);
		cfg(8'h80, 32'h1, 32'h64, 32'h0, 32'h0);
		i_field_source.send_pulses(1);
		repeat (20) @(posedge clk_sys_i);
		oc(2'b01);
		i_field_source.press_reset();
		oc(2'b00);
	endtask
	// Totalizer, clear at pulse end
	task automatic t_ar4;
		cfg(8'h91, 32'h1, 32'h3, 32'h0, 32'h2);
		i_field_source.send_pulses(3);
		oc(2'b11);
		repeat (2 * TK + 2) @(posedge clk_sys_i);
		oc(2'b00);
		rchk(setpoint_pkg::OFF_COUNT, 32'h0);
		rchk(setpoint_pkg::OFF_TOTAL, 32'h3);
	endtask
	task automatic t_down;
		cfg(8'ha8, 32'h32, 32'h3, 32'h0, 32'h5);
		i_field_source.send_pulses(3);
		oc(2'b10);
		rchk(setpoint_pkg::OFF_COUNT, 32'h3);
		cfg(8'ha8, 32'h32, 32'h3, 32'h0, 32'h0);
		i_field_source.send_pulses(3);
		rchk(setpoint_pkg::OFF_COUNT, 32'h0);
		cfg(8'hb0, 32'h32, 32'h2, 32'h0, 32'h2);
		i_field_source.send_pulses(2);
		oc(2'b10);
		repeat (2 * TK + 2) @(posedge clk_sys_i);
		oc(2'b00);
		rchk(setpoint_pkg::OFF_COUNT, 32'h2);
	endtask
	// Comparator mode; the reset in cfg adds the count of 2 left behind
	task automatic t_cmp;
		cfg(8'h99, 32'h1, 32'h2, 32'h3, 32'h3);
		i_field_source.send_pulses(1);
		repeat (20) @(posedge clk_sys_i);
		oc(2'b01);
		i_field_source.send_pulses(1);
		oc(2'b11);
		rchk(setpoint_pkg::OFF_TOTAL, 32'h5);
		i_field_source.press_reset();
		rchk(setpoint_pkg::OFF_TOTAL, 32'h7);
		cfg(8'hb8, 32'h1, 32'h3, 32'h0, 32'h0);
		i_field_source.send_pulses(1);
		chk({31'h0, out1_o}, 32'h0);
		i_field_source.send_pulses(1);
		chk({31'h0, out1_o}, 32'h1);
	endtask
	task automatic t_batch;
		cfg(8'hc3, 32'h2, 32'h2, 32'h0, 32'h2);
		i_field_source.send_pulses(2);
		oc(2'b10);
		rchk(setpoint_pkg::OFF_BATCH, 32'h1);
		rchk(setpoint_pkg::OFF_COUNT, 32'h0);
		i_field_source.send_pulses(2);
		oc(2'b11);
		rchk(setpoint_pkg::OFF_BATCH, 32'h0);
		repeat (20) @(posedge clk_sys_i);
		oc(2'b01);
		cfg(8'ha3, 32'h5, 32'h2, 32'h0, 32'h0);
		i_field_source.send_pulses(2);
		oc(2'b10);
		rchk(setpoint_pkg::OFF_COUNT, 32'h2);
	endtask
	task automatic t_freq;
		apb(1'b1, setpoint_pkg::OFF_TOUT, 32'h5);
		cfg(8'h84, 32'h0, 32'h0, 32'h0, 32'h0);
		i_field_source.send_pulses(2);
		rchk(setpoint_pkg::OFF_COUNT, 32'h2);
		repeat (7 * TK) @(posedge clk_sys_i);
		rchk(setpoint_pkg::OFF_COUNT, 32'h0);
	endtask
	// Free-running count, so wait on output two; a miss shows in the check after
	task automatic wait_o2(input logic v);
		int k;
		k = 0;
		while (out2_o !== v && k < 40)
		begin
			@(posedge clk_sys_i);
			k++;
		end
	endtask
	// Timer function in comparator mode, up then down
	task automatic t_timer;
		cfg(8'h9a, 32'h2, 32'h4, 32'h0, 32'h0);
		wait_o2(1'b1);
		chk({31'h0, out2_o}, 32'h1);
		chk({31'h0, out1_o}, 32'h0);
		rchk(setpoint_pkg::OFF_COUNT, 32'h0);
		wait_o2(1'b0);
		chk({31'h0, out2_o}, 32'h0);
		cfg(8'hba, 32'h2, 32'h4, 32'h0, 32'h0);
		wait_o2(1'b1);
		chk({31'h0, out2_o}, 32'h1);
		rchk(setpoint_pkg::OFF_COUNT, 32'h4);
	endtask
	// Main sequence
	initial
	begin
		clk_sys_i = 1'b0;
		reset_i = 1'b1;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0000_0000;
		repeat (16) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		@(posedge clk_sys_i);
		t_regs();
		t_out1();
		t_ar4();
		t_down();
		t_cmp();
		t_batch();
		t_freq();
		t_timer();
		give_verdict();
	end
endmodule // test_setpoint_counter_output_ctrl
